// *** cips_pkg.sv ***
// constants and types for the charge indicator and pack switch controller
package cips_pkg;
    localparam int unsigned CLK_HZ            = 250_000_000;
    localparam int unsigned ALERT_US          = 256;
    localparam int unsigned ALERT_CYC         = (CLK_HZ / 1_000_000) * ALERT_US;
    localparam int unsigned BLINK_HZ          = 1;
    localparam int unsigned BLINK_HALF_CYC    = CLK_HZ / (2 * BLINK_HZ);
    localparam int unsigned DLY_SHORT_MS      = 25;
    localparam int unsigned DLY_SHORT_CYC     = (CLK_HZ / 1000) * DLY_SHORT_MS;
    localparam longint unsigned DLY_LONG_MS   = 12500;
    localparam longint unsigned DLY_LONG_CYC  = (64'(CLK_HZ) / 64'd1000) * DLY_LONG_MS;
    localparam int unsigned WAKE_HOLD_CYC     = 250_000_000;
    localparam int unsigned SHIP_EXIT_CYC     = 250_000_000;
    localparam int unsigned RESET_OFF_CYC     = 62_500_000;

    // avalon register word addresses (word index)
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h1;
    localparam logic [3:0] ADDR_FLAG   = 4'h2;
    localparam logic [3:0] ADDR_MASK   = 4'h3;
    localparam logic [3:0] ADDR_MODE   = 4'h4;

    // ctrl field positions
    localparam int unsigned CTRL_MODE_LO   = 0;
    localparam int unsigned CTRL_OVR       = 2;
    localparam int unsigned CTRL_DLY       = 3;
    localparam int unsigned CTRL_IND_DIS   = 4;

    localparam logic [1:0] MODE_NORMAL   = 2'h0;
    localparam logic [1:0] MODE_SHUTDOWN = 2'h1;
    localparam logic [1:0] MODE_SHIP     = 2'h2;
    localparam logic [1:0] MODE_RESET    = 2'h3;

    localparam logic [7:0] MASK_RESET    = 8'h00;

    typedef enum logic [2:0] {
        CIPS_NORMAL,
        CIPS_WAIT,
        CIPS_ARMED,
        CIPS_RST_OFF,
        CIPS_SHIP,
        CIPS_SHUTDOWN
    } cips_state_t;
endpackage

// *** cips_ctrl.sv ***
// charge indicator, alert pulse, event flags and pack switch sequencer
//
// Local design decisions: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ns
// =====================================================================
// How it works
// - indicator low when charging, released idle, 1 Hz blink on suspend
// - indicator disable bit releases the indicator pin
// - reportable event gives one 256 us low alert pulse
// - flags latch at one and clear when software reads them
// - status bits always show live condition, no latching
// - mask suppresses pulse; power-up event cannot be masked
// - flags set regardless of mask
// - ship request without adapter: switch off after delay, enter ship
// - ship request with adapter, no override: waits for delay and removal
// - writing normal before removal aborts ship; override restores switch
// - ship with override: switch off after delay, ship after removal
// - reset request cycles switch after delay; wake hold resets at once; both need override or no adapter
// - during reset with override, converter held high impedance
// - shutdown request without adapter enters shutdown after delay
// - delay is 25 ms or 12.5 s by delay bit
// - shutdown request with adapter ignored, mode back to normal
// - shutdown left only on adapter plug-in, registers to defaults
// - in shutdown wake pin ignored and its pull-up off
// - ship left by wake hold or adapter, registers to defaults
// - pulse comes from the event itself even if flag already set
// - mask one suppresses, zero allows, default allows
module cips_ctrl
    import cips_pkg::*;
#(
    parameter int unsigned NUM_EV       = 8,
    parameter longint unsigned DLY_LONG = DLY_LONG_CYC,
    parameter int unsigned DLY_SHORT    = DLY_SHORT_CYC,
    parameter int unsigned BLINK_HALF   = BLINK_HALF_CYC,
    parameter int unsigned WAKE_HOLD    = WAKE_HOLD_CYC,
    parameter int unsigned SHIP_EXIT    = SHIP_EXIT_CYC,
    parameter int unsigned RESET_OFF    = RESET_OFF_CYC
) (
    input  wire logic              ref_clk_i,          // 250 MHz clock
    input  wire logic              rst_b_i,            // sync reset, active low
    input  wire logic              clk_en_i,           // freezes all state when low
    input  wire logic [3:0]        avs_address_i,      // word address
    input  wire logic              avs_read_i,         // read strobe
    input  wire logic              avs_write_i,        // write strobe
    input  wire logic [31:0]       avs_writedata_i,    // write data
    input  wire logic [3:0]        avs_byteenable_i,   // byte enables
    output logic [31:0]            avs_readdata_o,     // read data
    output logic                   avs_waitrequest_o,  // wait request
    input  wire logic [NUM_EV-1:0] ev_cond_i,          // event status conditions (async)
    input  wire logic              charging_i,         // charging or recharging (async)
    input  wire logic              suspended_i,        // charge suspended (async)
    input  wire logic              adapter_input_i,    // adapter present (async)
    input  wire logic              wake_button_pin_i,  // wake pin level, low active (async)
    output logic                   ind_o,              // indicator pin output value
    output logic                   ind_oe_b_o,         // indicator drive enable, low drives
    output logic                   alert_b_o,          // alert pin, active low
    output logic                   battery_switch_o,   // battery switch on
    output logic                   input_high_impedance_o, // converter held high impedance
    output logic                   serial_enable_o,    // serial interface enabled
    output logic                   wake_pullup_o,      // wake pin pull-up enabled
    output logic                   charger_off_o       // whole charger shut down
);
    import cips_pkg::*;

    initial begin
        if (NUM_EV < 2 || NUM_EV > 16) $error("NUM_EV out of range");
        if (BLINK_HALF < 1 || WAKE_HOLD < 1 || DLY_SHORT < 1) $error("bad counts");
    end

    // =================================================================
    // input synchronisers
    localparam int unsigned SW = NUM_EV + 4;
    logic [SW-1:0] sync_a;
    logic [SW-1:0] sync_b;
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            sync_a <= {1'b1, {(SW-1){1'b0}}};
            sync_b <= {1'b1, {(SW-1){1'b0}}};
        end else if (clk_en_i) begin
            sync_a <= {wake_button_pin_i, adapter_input_i, suspended_i, charging_i, ev_cond_i};
            sync_b <= sync_a;
        end
    end
    logic [NUM_EV-1:0] ev_s;
    logic charging_s;
    logic suspended_s;
    logic adapter_s;
    logic wake_s;
    assign ev_s       = sync_b[NUM_EV-1:0];
    assign charging_s = sync_b[NUM_EV];
    assign suspended_s= sync_b[NUM_EV+1];
    assign adapter_s  = sync_b[NUM_EV+2];
    assign wake_s     = sync_b[NUM_EV+3];

    // =================================================================
    // registers and software-visible state
    logic [1:0]        mode_field;
    logic              ovr_bit;
    logic              dly_bit;
    logic              ind_dis;
    logic [NUM_EV-1:0] flag;
    logic [NUM_EV-1:0] mask;
    logic [NUM_EV-1:0] ev_prev;
    logic [NUM_EV-1:0] ev_rise;
    logic              por_pend;
    logic              regs_clear;
    logic              wr_ctrl;
    logic              wr_mask;
    logic              rd_flag;
    cips_state_t       state;

    assign ev_rise  = ev_s & ~ev_prev;
    assign wr_ctrl  = avs_write_i && avs_waitrequest_o && avs_address_i == ADDR_CTRL && avs_byteenable_i[0];
    assign wr_mask  = avs_write_i && avs_waitrequest_o && avs_address_i == ADDR_MASK && avs_byteenable_i[0];
    assign rd_flag  = avs_read_i && avs_waitrequest_o && avs_address_i == ADDR_FLAG;

    function automatic logic mode_is(input logic [31:0] d, input logic [1:0] m);
        return d[CTRL_MODE_LO +: 2] == m;
    endfunction

    // one wait cycle then acknowledge
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o    <= '0;
        end else if (clk_en_i) begin
            avs_waitrequest_o <= 1'b1;
            if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
                avs_waitrequest_o <= 1'b0;
                avs_readdata_o    <= '0;
                if (avs_read_i) begin
                    unique case (avs_address_i)
                        ADDR_CTRL:   avs_readdata_o[4:0] <= {ind_dis, dly_bit, ovr_bit, mode_field};
                        ADDR_STATUS: avs_readdata_o[NUM_EV-1:0] <= ev_s;
                        ADDR_FLAG:   avs_readdata_o[NUM_EV-1:0] <= flag;
                        ADDR_MASK:   avs_readdata_o[NUM_EV-1:0] <= mask;
                        ADDR_MODE:   avs_readdata_o[2:0] <= 3'(state);
                        default:     avs_readdata_o <= '0;
                    endcase
                end
            end
        end
    end

    // =================================================================
    // control register; mode field written by software, cleared by sequencer
    logic mode_clr;
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i || regs_clear) begin
            mode_field <= MODE_NORMAL;
            ovr_bit    <= 1'b0;
            dly_bit    <= 1'b0;
            ind_dis    <= 1'b0;
        end else if (clk_en_i) begin
            if (wr_ctrl && serial_enable_o) begin
                ovr_bit <= avs_writedata_i[CTRL_OVR];
                dly_bit <= avs_writedata_i[CTRL_DLY];
                ind_dis <= avs_writedata_i[CTRL_IND_DIS];
                if (adapter_s && mode_is(avs_writedata_i, MODE_SHUTDOWN))
                    mode_field <= MODE_NORMAL;
                else if (adapter_s && !avs_writedata_i[CTRL_OVR] && mode_is(avs_writedata_i, MODE_RESET))
                    mode_field <= MODE_NORMAL;
                else
                    mode_field <= avs_writedata_i[CTRL_MODE_LO +: 2];
            end else if (mode_clr) begin
                mode_field <= MODE_NORMAL;
            end
        end
    end

    // mask register, default zero allows pulses
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i || regs_clear) begin
            mask <= MASK_RESET;
        end else if (clk_en_i && wr_mask && serial_enable_o) begin
            mask <= avs_writedata_i[NUM_EV-1:0];
        end
    end

    // =================================================================
    // event flags: set wins over read clear
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i || regs_clear) begin
            flag    <= '0;
            ev_prev <= '0;
        end else if (clk_en_i) begin
            ev_prev <= ev_s;
            flag    <= (rd_flag ? '0 : flag) | ev_rise;
        end
    end

    // =================================================================
    // alert pulse, fixed width, unmaskable power-up pulse
    localparam int unsigned AW = $clog2(ALERT_CYC + 1);
    logic [AW-1:0] alert_cnt;
    logic          alert_trig;
    assign alert_trig = por_pend || |(ev_rise & ~mask);
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            alert_cnt <= '0;
            alert_b_o <= 1'b1;
            por_pend  <= 1'b1;
        end else if (clk_en_i) begin
            por_pend <= 1'b0;
            if (alert_cnt != '0) begin
                alert_cnt <= alert_cnt - 1'b1;
                alert_b_o <= (alert_cnt == AW'(1));
            end else if (alert_trig) begin
                alert_cnt <= AW'(ALERT_CYC);
                alert_b_o <= 1'b0;
            end
        end
    end

    // =================================================================
    // indicator pin with 1 Hz blink
    localparam int unsigned BW = $clog2(BLINK_HALF + 1);
    logic [BW-1:0] blink_cnt;
    logic          blink_ph;
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            blink_cnt <= '0;
            blink_ph  <= 1'b0;
        end else if (clk_en_i) begin
            if (blink_cnt == BW'(BLINK_HALF - 1)) begin
                blink_cnt <= '0;
                blink_ph  <= ~blink_ph;
            end else begin
                blink_cnt <= blink_cnt + 1'b1;
            end
        end
    end
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            ind_o      <= 1'b0;
            ind_oe_b_o <= 1'b1;
        end else if (clk_en_i) begin
            ind_o <= 1'b0;
            if (ind_dis || charger_off_o)
                ind_oe_b_o <= 1'b1;
            else if (suspended_s)
                ind_oe_b_o <= blink_ph;
            else
                ind_oe_b_o <= !charging_s;
        end
    end

    // =================================================================
    // pack switch sequencer
    logic [39:0] tmr;
    logic [31:0] wake_cnt;
    logic        wake_held;
    logic        wake_exit;
    logic [1:0]  pend_mode;
    assign wake_held = wake_cnt == WAKE_HOLD;
    assign wake_exit = wake_cnt >= SHIP_EXIT;

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            wake_cnt <= '0;
        end else if (clk_en_i) begin
            if (wake_s || state == CIPS_SHUTDOWN)
                wake_cnt <= '0;
            else if (!wake_exit || wake_cnt <= WAKE_HOLD)
                wake_cnt <= wake_cnt + 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            state                  <= CIPS_NORMAL;
            tmr                    <= '0;
            pend_mode              <= MODE_NORMAL;
            mode_clr               <= 1'b0;
            regs_clear             <= 1'b0;
            battery_switch_o       <= 1'b1;
            input_high_impedance_o <= 1'b0;
            serial_enable_o        <= 1'b1;
            wake_pullup_o          <= 1'b1;
            charger_off_o          <= 1'b0;
        end else if (clk_en_i) begin
            mode_clr   <= 1'b0;
            regs_clear <= 1'b0;
            unique case (state)
                CIPS_NORMAL: begin
                    if (wake_held && (ovr_bit || !adapter_s)) begin
                        state                  <= CIPS_RST_OFF;
                        tmr                    <= 40'(RESET_OFF);
                        battery_switch_o       <= 1'b0;
                        input_high_impedance_o <= ovr_bit;
                    end else if (mode_field != MODE_NORMAL && !wr_ctrl) begin
                        state     <= CIPS_WAIT;
                        pend_mode <= mode_field;
                        tmr       <= dly_bit ? 40'(DLY_LONG) : 40'(DLY_SHORT);
                    end
                end
                CIPS_WAIT: begin
                    if (mode_field == MODE_NORMAL) begin
                        state            <= CIPS_NORMAL;
                        battery_switch_o <= 1'b1;
                    end else if (tmr != '0) begin
                        tmr <= tmr - 1'b1;
                    end else if (pend_mode == MODE_RESET) begin
                        state                  <= CIPS_RST_OFF;
                        tmr                    <= 40'(RESET_OFF);
                        battery_switch_o       <= 1'b0;
                        input_high_impedance_o <= ovr_bit;
                    end else if (pend_mode == MODE_SHUTDOWN && !adapter_s) begin
                        state            <= CIPS_SHUTDOWN;
                        battery_switch_o <= 1'b0;
                        serial_enable_o  <= 1'b0;
                        wake_pullup_o    <= 1'b0;
                        charger_off_o    <= 1'b1;
                    end else if (pend_mode == MODE_SHIP) begin
                        if (!adapter_s) begin
                            state            <= CIPS_SHIP;
                            battery_switch_o <= 1'b0;
                            serial_enable_o  <= 1'b0;
                        end else begin
                            state            <= CIPS_ARMED;
                            battery_switch_o <= !ovr_bit;
                        end
                    end else begin
                        state    <= CIPS_NORMAL;
                        mode_clr <= 1'b1;
                    end
                end
                CIPS_ARMED: begin
                    if (mode_field == MODE_NORMAL) begin
                        state            <= CIPS_NORMAL;
                        battery_switch_o <= 1'b1;
                    end else if (!adapter_s) begin
                        state            <= CIPS_SHIP;
                        battery_switch_o <= 1'b0;
                        serial_enable_o  <= 1'b0;
                    end
                end
                CIPS_RST_OFF: begin
                    if (tmr != '0) begin
                        tmr <= tmr - 1'b1;
                    end else begin
                        state                  <= CIPS_NORMAL;
                        battery_switch_o       <= 1'b1;
                        input_high_impedance_o <= 1'b0;
                        mode_clr               <= 1'b1;
                    end
                end
                CIPS_SHIP: begin
                    if (adapter_s || wake_exit) begin
                        state            <= CIPS_NORMAL;
                        battery_switch_o <= 1'b1;
                        serial_enable_o  <= 1'b1;
                        regs_clear       <= 1'b1;
                    end
                end
                CIPS_SHUTDOWN: begin
                    if (adapter_s) begin
                        state            <= CIPS_NORMAL;
                        battery_switch_o <= 1'b1;
                        serial_enable_o  <= 1'b1;
                        wake_pullup_o    <= 1'b1;
                        charger_off_o    <= 1'b0;
                        regs_clear       <= 1'b1;
                    end
                end
                default: state <= CIPS_NORMAL;
            endcase
        end
    end
endmodule // cips_ctrl

// *** cips_ctrl_asserts.sv ***
// pin level assertions for the pack switch controller
`timescale 1ns/1ns
module cips_ctrl_asserts
    import cips_pkg::*;
(
    input wire logic ref_clk_i,              // clock
    input wire logic rst_b_i,                // reset, active low
    input wire logic clk_en_i,               // clock enable
    input wire logic avs_read_i,             // read strobe
    input wire logic avs_write_i,            // write strobe
    input wire logic avs_waitrequest_o,      // wait request
    input wire logic charging_i,             // charging
    input wire logic suspended_i,            // suspended
    input wire logic adapter_input_i,        // adapter present
    input wire logic ind_o,                  // indicator value
    input wire logic ind_oe_b_o,             // indicator enable
    input wire logic alert_b_o,              // alert pin
    input wire logic battery_switch_o,       // switch on
    input wire logic input_high_impedance_o, // converter hiz
    input wire logic serial_enable_o,        // serial on
    input wire logic wake_pullup_o,          // wake pull-up
    input wire logic charger_off_o           // charger off
);
    logic [16:0] alert_len;
    // ==========================================
    // alert low-time counter
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i || alert_b_o) alert_len <= 17'h00000;
        else if (clk_en_i) alert_len <= alert_len + 17'h00001;
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);
    a_ind_open_drain: assert property (ind_o == 1'b0)
        else $error("indicator drives high");
    a_ind_idle_rel: assert property ((clk_en_i && !charging_i && !suspended_i)[*6] |-> ind_oe_b_o)
        else $error("indicator held low while idle");
    a_alert_pulse_len: assert property ($rose(alert_b_o) |-> alert_len == 17'(ALERT_CYC))
        else $error("alert pulse width wrong");
    a_alert_no_stretch: assert property (alert_len <= 17'(ALERT_CYC))
        else $error("alert pulse stretched");
    a_pwrup_alert: assert property ($rose(rst_b_i) |-> ##[1:4] !alert_b_o)
        else $error("no power-up alert");
    a_shut_pins_off: assert property (charger_off_o |-> !battery_switch_o && !serial_enable_o && !wake_pullup_o)
        else $error("shutdown pins wrong");
    a_serial_off_sw: assert property (!serial_enable_o |-> !battery_switch_o)
        else $error("switch on with serial off");
    a_hiz_serial_on: assert property (input_high_impedance_o |-> serial_enable_o)
        else $error("hiz outside system reset");
    a_adapter_wakes: assert property (not ((clk_en_i && adapter_input_i && !serial_enable_o)[*8]))
        else $error("adapter did not wake device");
    a_ack_next_cyc: assert property (clk_en_i && (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("bus answer late");
endmodule // cips_ctrl_asserts

bind cips_ctrl cips_ctrl_asserts chk (.*);

// *** cips_host_model.sv ***
// host side pins: indicator pull-up and alert pulse counter
`timescale 1ns/1ns
module cips_host_model (
    input  wire logic ref_clk_i,   // clock
    input  wire logic rst_b_i,     // reset, active low
    input  wire logic ind_o,       // indicator value
    input  wire logic ind_oe_b_o,  // indicator enable, low drives
    input  wire logic alert_b_o,   // alert pin
    output logic      stat_line_o, // resolved indicator wire
    output int        alert_cnt_o  // alert pulses seen
);
    logic alert_q;
    // released line pulled high by the led supply
    assign stat_line_o = ind_oe_b_o ? 1'b1 : ind_o;
    always_ff @(posedge ref_clk_i) begin
        alert_q <= alert_b_o;
        if (!rst_b_i) alert_cnt_o <= 0;
        else if (alert_q && !alert_b_o) alert_cnt_o <= alert_cnt_o + 1;
    end
endmodule // cips_host_model

// *** tb_top.sv ***
// testbench for the pack switch controller
`timescale 1ns/1ns
module tb_top;
    import cips_pkg::*;
    typedef struct packed {logic w; logic [3:0] a; logic [7:0] d; logic [7:0] e; logic l;} cips_row_t;
    logic        ref_clk_i, rst_b_i, clk_en_i, avs_read_i, avs_write_i, avs_waitrequest_o, stat_line;
    logic [3:0]  avs_address_i, avs_byteenable_i;
    logic [31:0] avs_writedata_i, avs_readdata_o, q;
    logic [7:0]  ev_cond_i;
    logic        charging_i, suspended_i, adapter_input_i, wake_button_pin_i, ind_o, ind_oe_b_o;
    logic        alert_b_o, battery_switch_o, input_high_impedance_o, serial_enable_o, wake_pullup_o, charger_off_o;
    int          error_cnt, samples_checked, n_alert, hi, a0;
    cips_row_t   rows [10] = '{
        '{1'b0, ADDR_CTRL, 8'h00, 8'h00, 1'b0}, '{1'b0, ADDR_MASK, 8'h00, 8'h00, 1'b0},
        '{1'b0, ADDR_MODE, 8'h00, 8'h00, 1'b0}, '{1'b0, 4'hE, 8'h00, 8'h00, 1'b0},
        '{1'b0, ADDR_STATUS, 8'h00, 8'h03, 1'b0}, '{1'b1, ADDR_MASK, 8'hA5, 8'h00, 1'b0},
        '{1'b0, ADDR_MASK, 8'h00, 8'hA5, 1'b0}, '{1'b1, ADDR_CTRL, 8'h10, 8'h00, 1'b1},
        '{1'b0, ADDR_CTRL, 8'h00, 8'h10, 1'b1}, '{1'b1, ADDR_CTRL, 8'h00, 8'h00, 1'b0}};

    cips_ctrl #(.DLY_LONG(80), .DLY_SHORT(40), .BLINK_HALF(20), .WAKE_HOLD(30), .SHIP_EXIT(30),
        .RESET_OFF(20)) uut (.*);
    cips_host_model host (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .ind_o(ind_o), .ind_oe_b_o(ind_oe_b_o),
        .alert_b_o(alert_b_o), .stat_line_o(stat_line), .alert_cnt_o(n_alert));

    // ==========================================
    // tasks
    task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %0t val %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk_pin(input logic g, input logic e);
        chk_reg(32'(g), 32'(e));
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        avs_address_i   <= a;
        avs_writedata_i <= {24'h000000, d};
        avs_write_i     <= w;
        avs_read_i      <= !w;
        @(posedge ref_clk_i);
        while (avs_waitrequest_o !== 1'b0) @(posedge ref_clk_i);
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i  <= 1'b0;
        @(posedge ref_clk_i);
    endtask
    task automatic pins(input logic s, input logic e);
        chk_pin(battery_switch_o, s);
        chk_pin(serial_enable_o, e);
    endtask
    task automatic hold_wake(input int n);
        wake_button_pin_i <= 1'b0;
        cyc(n);
        wake_button_pin_i <= 1'b1;
        cyc(5);
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end
    initial begin
        cyc(80000);
        error_cnt++;
        final_report();
    end
    // ==========================================
    // main sequence
    initial begin
        {rst_b_i, avs_read_i, avs_write_i, suspended_i, adapter_input_i, ev_cond_i} = '0;
        {clk_en_i, charging_i, wake_button_pin_i} = 3'h7;
        {avs_address_i, avs_writedata_i, avs_byteenable_i} = {36'h0, 4'hF};
        cyc(5);
        rst_b_i   <= 1'b1;
        ev_cond_i <= 8'h03;
        cyc(2);
        foreach (rows[i]) begin
            bus(rows[i].w, rows[i].a, rows[i].d);
            cyc(6);
            if (!rows[i].w) chk_reg(q, {24'h000000, rows[i].e});
            chk_pin(stat_line, rows[i].l);
        end
        charging_i  <= 1'b0;
        suspended_i <= 1'b1;
        cyc(10);
        repeat (200) begin
            @(posedge ref_clk_i);
            hi += int'(stat_line === 1'b1);
        end
        chk_pin(hi >= 80 && hi <= 120, 1'b1);
        suspended_i <= 1'b0;
        while (alert_b_o !== 1'b1) @(posedge ref_clk_i);
        bus(1'b0, ADDR_FLAG, 8'h00);
        chk_reg(q & 32'h3, 32'h3);
        bus(1'b0, ADDR_FLAG, 8'h00);
        chk_reg(q & 32'h3, 32'h0);
        bus(1'b1, ADDR_MASK, 8'hFF);
        a0 = n_alert;
        ev_cond_i <= 8'h07;
        cyc(10);
        chk_reg(32'(n_alert), 32'(a0));
        ev_cond_i <= 8'h03;
        bus(1'b1, ADDR_MASK, 8'h00);
        ev_cond_i <= 8'h07;
        cyc(10);
        chk_reg(32'(n_alert), 32'(a0 + 1));
        ev_cond_i <= 8'h0F;
        cyc(5);
        bus(1'b0, ADDR_FLAG, 8'h00);
        chk_reg(q & 32'hC, 32'hC);
        bus(1'b1, ADDR_MASK, 8'h5A);
        bus(1'b1, ADDR_CTRL, 8'h02);
        cyc(30);
        pins(1'b1, 1'b1);
        clk_en_i <= 1'b0;
        cyc(30);
        clk_en_i <= 1'b1;
        cyc(5);
        pins(1'b1, 1'b1);
        cyc(15);
        pins(1'b0, 1'b0);
        hold_wake(40);
        pins(1'b1, 1'b1);
        avs_byteenable_i <= 4'hE;
        bus(1'b1, ADDR_MASK, 8'h3C);
        avs_byteenable_i <= 4'hF;
        bus(1'b0, ADDR_MASK, 8'h00);
        chk_reg(q, 32'h0);
        bus(1'b1, ADDR_CTRL, 8'h0A);
        cyc(60);
        pins(1'b1, 1'b1);
        cyc(30);
        pins(1'b0, 1'b0);
        adapter_input_i <= 1'b1;
        cyc(10);
        pins(1'b1, 1'b1);
        bus(1'b1, ADDR_CTRL, 8'h05);
        bus(1'b0, ADDR_CTRL, 8'h00);
        chk_reg(q & 32'h3, 32'h0);
        bus(1'b1, ADDR_CTRL, 8'h03);
        bus(1'b0, ADDR_CTRL, 8'h00);
        chk_reg(q & 32'h3, 32'h0);
        hold_wake(40);
        pins(1'b1, 1'b1);
        bus(1'b1, ADDR_CTRL, 8'h02);
        cyc(60);
        pins(1'b1, 1'b1);
        bus(1'b1, ADDR_CTRL, 8'h00);
        adapter_input_i <= 1'b0;
        cyc(60);
        pins(1'b1, 1'b1);
        adapter_input_i <= 1'b1;
        bus(1'b1, ADDR_CTRL, 8'h06);
        cyc(60);
        pins(1'b0, 1'b1);
        bus(1'b1, ADDR_CTRL, 8'h04);
        cyc(5);
        pins(1'b1, 1'b1);
        bus(1'b1, ADDR_CTRL, 8'h06);
        cyc(60);
        adapter_input_i <= 1'b0;
        cyc(10);
        pins(1'b0, 1'b0);
        adapter_input_i <= 1'b1;
        cyc(10);
        bus(1'b1, ADDR_CTRL, 8'h07);
        cyc(30);
        chk_pin(battery_switch_o, 1'b1);
        cyc(20);
        chk_pin(battery_switch_o | !input_high_impedance_o, 1'b0);
        cyc(40);
        pins(1'b1, 1'b1);
        chk_pin(input_high_impedance_o, 1'b0);
        wake_button_pin_i <= 1'b0;
        cyc(36);
        chk_pin(battery_switch_o, 1'b0);
        wake_button_pin_i <= 1'b1;
        cyc(40);
        adapter_input_i <= 1'b0;
        bus(1'b1, ADDR_MASK, 8'h5A);
        bus(1'b1, ADDR_CTRL, 8'h01);
        cyc(60);
        chk_pin(charger_off_o, 1'b1);
        hold_wake(40);
        chk_pin(charger_off_o & !wake_pullup_o & !battery_switch_o, 1'b1);
        adapter_input_i <= 1'b1;
        cyc(10);
        pins(1'b1, 1'b1);
        bus(1'b0, ADDR_MASK, 8'h00);
        chk_reg(q, 32'h0);
        bus(1'b1, ADDR_CTRL, 8'h10);
        rst_b_i <= 1'b0;
        cyc(5);
        rst_b_i <= 1'b1;
        bus(1'b0, ADDR_CTRL, 8'h00);
        chk_reg(q, 32'h0);
        final_report();
    end
endmodule // tb_top
